// ### verilog/emu_pkg.sv
// Constants, register offsets and field positions for the emulation unit.
// Assumes a 32-bit APB slave with one register per aligned word.
package emu_pkg;

   // ***************************************************************
   // Sizes
   // ***************************************************************
   localparam int ADDR_W      = 16;
   localparam int DATA_W      = 16;
   localparam int TRACE_DEPTH = 16;
   localparam int NUM_PROG    = 3;
   localparam int BREAK_DELAY = 2;   // Instructions between data match and break

   // ***************************************************************
   // Register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFS_PROG_CMP_1   = 8'h00;
   localparam logic [7:0] OFS_PROG_CMP_2   = 8'h04;
   localparam logic [7:0] OFS_PROG_CMP_3   = 8'h08;
   localparam logic [7:0] OFS_PROG_CNT_1   = 8'h0C;
   localparam logic [7:0] OFS_PROG_CNT_2   = 8'h10;
   localparam logic [7:0] OFS_PROG_CNT_3   = 8'h14;
   localparam logic [7:0] OFS_DATA_ADDR    = 8'h18;
   localparam logic [7:0] OFS_DATA_MASK    = 8'h1C;
   localparam logic [7:0] OFS_DATA_VALUE   = 8'h20;
   localparam logic [7:0] OFS_EMU_MODE_REG0        = 8'h24;
   localparam logic [7:0] OFS_FIRST_STATUS_REG      = 8'h28;
   localparam logic [7:0] OFS_STATUS1      = 8'h2C;
   localparam logic [7:0] OFS_TRACE_READ   = 8'h30;

   // ***************************************************************
   // Mode register fields
   // ***************************************************************
   localparam int MODE_READ_ADDR_EN   = 0;
   localparam int MODE_WRITE_ADDR_EN  = 1;
   localparam int MODE_READ_VALUE_EN  = 2;
   localparam int MODE_WRITE_VALUE_EN = 3;
   localparam int MODE_COMBINED_EN    = 4;
   localparam int MODE_SINGLE_STEP    = 5;
   localparam int MODE_BRANCH_BREAK   = 6;
   localparam int MODE_INTR_BREAK     = 7;
   localparam int MODE_LOOP_BREAK     = 8;
   localparam int MODE_TRACE_FULL     = 9;

   // ***************************************************************
   // Status register fields
   // ***************************************************************
   localparam int ST_DATA_VALUE  = 0;
   localparam int ST_DATA_ADDR   = 1;
   localparam int ST_COMBINED    = 2;
   localparam int ST_PROG_FLAG_1 = 5;   // Flags 1..3 occupy bits 5..7
   localparam int ST_PROG_EN_1   = 8;   // Enables 1..3 occupy bits 8..10
   localparam int ST_BRANCH      = 11;
   localparam int ST_INTR        = 12;
   localparam int ST_TRACE_FULL  = 13;
   localparam int ST_STEP        = 14;
   localparam int ST_LOOP        = 15;

   localparam logic [15:0] MODE_RESET   = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] EMPTY_ENTRY  = 16'hFFFF;

endpackage

// ### verilog/emu_delay_line.sv
// Fixed delay of a single-bit request, counted in retired instructions.
// Assumes instr_done pulses once per completed instruction.
`timescale 1ns/1ps
`default_nettype none
module emu_delay_line
   import emu_pkg::*;
#(
   parameter int STAGES = BREAK_DELAY
)
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Request
   input  wire logic instr_done,
   input  wire logic req_in,
   output logic      req_out
);

   initial
   begin
      if (STAGES < 2)
         $error("emu_delay_line needs at least two stages");
   end

   logic [STAGES-1:0] pipe_reg;

   // Shift on each retired instruction; new request joins the head
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pipe_reg <= '0;
      else if (instr_done)
         pipe_reg <= {pipe_reg[STAGES-2:0], req_in};
      else if (req_in)
         pipe_reg[0] <= 1'b1;
   end

   assign req_out = pipe_reg[STAGES-1] & instr_done;

endmodule
`default_nettype wire

// ### verilog/emu_trace_fifo.sv
// Sixteen-entry discontinuity trace store with tag bit, read newest first.
// Assumes one push and at most one pop per cycle.
`timescale 1ns/1ps
`default_nettype none
module emu_trace_fifo
   import emu_pkg::*;
#(
   parameter int DEPTH = TRACE_DEPTH,
   parameter int WIDTH = ADDR_W
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Record side
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_addr,
   input  wire logic             push_tag,
   // Readout side
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head_addr,
   output logic                  head_tag,
   output logic                  full
);

   initial
   begin
      // Empty pattern is only as wide as the package constant
      if (DEPTH < 2 || WIDTH < 1 || WIDTH > $bits(EMPTY_ENTRY))
         $error("emu_trace_fifo parameters out of range");
   end

   logic [WIDTH:0] mem_reg [DEPTH];
   logic [$clog2(DEPTH+1)-1:0] count_reg;

   // Shift register, newest at index 0
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= {1'b1, EMPTY_ENTRY[WIDTH-1:0]};
         count_reg <= '0;
      end
      else if (push)
      begin
         mem_reg[0] <= {push_tag, push_addr};
         for (int i = 1; i < DEPTH; i++)
            mem_reg[i] <= mem_reg[i-1];
         if (count_reg != DEPTH[$bits(count_reg)-1:0])
            count_reg <= count_reg + 1'b1;
      end
      else if (pop)
      begin
         for (int i = 0; i < DEPTH-1; i++)
            mem_reg[i] <= mem_reg[i+1];
         mem_reg[DEPTH-1] <= {1'b1, EMPTY_ENTRY[WIDTH-1:0]};
         if (count_reg != '0)
            count_reg <= count_reg - 1'b1;
      end
   end

   assign head_addr = mem_reg[0][WIDTH-1:0];
   assign head_tag  = mem_reg[0][WIDTH];
   assign full      = (count_reg == DEPTH[$bits(count_reg)-1:0]);

endmodule
`default_nettype wire

// ### verilog/emu_breakpoint.sv
// Emulation unit: breakpoint conditions, trace buffer and APB registers.
// Assumes core strobes are synchronous to pclk and one cycle wide.
// Operation
// - Three program address comparators, each with an occurrence counter.
// - Fetch address match decrements the paired counter.
// - Match leaving counter at zero requests the breakpoint interrupt.
// - Count 0 or 1 breaks every fetch; n breaks on nth.
// - Writing 0 to an enable bit disables that program breakpoint.
// - Per-comparator flag shows which program match caused the break.
// - Data address equal to compare register starts data address break.
// - Mask register excludes address bits from data address compare.
// - Data value match only on memory transactions.
// - Combine bit enables combined break; flagged in combined status bit.
// - Data breaks after transaction; program breaks during fetch.
// - Data value break lands two instructions later.
// - Data address break delayed to the same two instructions.
// - Single step re-breaks after one instruction on handler return.
// - Break on branches, calls, returns, PC writes, interrupts except trap.
// - Break on block-repeat wrap from last to first address.
// - Any met condition asserts the breakpoint interrupt.
// - Sixteen-entry buffer holds discontinuity addresses only.
// - Discontinuity addresses kept last-in first-out.
// - Trace-full break option, else keep last 16; read leaves ones.
// - Trace readout returns newest entry then advances with its tag.
`timescale 1ns/1ps
`default_nettype none
module emu_breakpoint
   import emu_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Core fetch side
   input  wire logic              fetch_valid,
   input  wire logic [ADDR_W-1:0] fetch_addr,
   input  wire logic              instr_done,
   // Core data side
   input  wire logic              data_valid,
   input  wire logic              data_write,
   input  wire logic              data_mem,
   input  wire logic [ADDR_W-1:0] data_addr,
   input  wire logic [DATA_W-1:0] data_bus,
   // Core flow events
   input  wire logic              branch_taken,
   input  wire logic              intr_start,
   input  wire logic              intr_is_trap,
   input  wire logic              loop_wrap,
   input  wire logic [ADDR_W-1:0] flow_addr,
   input  wire logic              flow_two_word,
   input  wire logic              handler_active,
   input  wire logic              handler_return,
   // Breakpoint interrupt to core
   output logic                   breakpoint_interrupt
);

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [ADDR_W-1:0] prog_cmp_reg [NUM_PROG];
   logic [15:0]       prog_match_counter_reg [NUM_PROG];
   logic [ADDR_W-1:0] data_addr_compare_reg;
   logic [ADDR_W-1:0] data_addr_mask_reg;
   logic [DATA_W-1:0] data_value_compare_reg;
   logic [15:0]       emu_mode_reg0_reg;
   logic [15:0]       first_status_reg_reg;
   logic              step_armed_reg;
   logic              bi_reg;

   // Bus decode
   wire access   = psel & penable;
   wire wr_en    = access & pwrite;
   wire rd_en    = access & ~pwrite;
   wire hit_mode = (paddr == OFS_EMU_MODE_REG0);
   wire hit_stat = (paddr == OFS_FIRST_STATUS_REG);
   wire hit_dadr = (paddr == OFS_DATA_ADDR);
   wire hit_dmsk = (paddr == OFS_DATA_MASK);
   wire hit_dval = (paddr == OFS_DATA_VALUE);
   wire hit_trc  = (paddr == OFS_TRACE_READ);

   function automatic logic [7:0] cmp_ofs(input int idx);
      cmp_ofs = OFS_PROG_CMP_1 + 8'(4 * idx);
   endfunction

   function automatic logic [7:0] cnt_ofs(input int idx);
      cnt_ofs = OFS_PROG_CNT_1 + 8'(4 * idx);
   endfunction

   // Mode bits
   wire rd_addr_en   = emu_mode_reg0_reg[MODE_READ_ADDR_EN];
   wire wr_addr_en   = emu_mode_reg0_reg[MODE_WRITE_ADDR_EN];
   wire rd_value_en  = emu_mode_reg0_reg[MODE_READ_VALUE_EN];
   wire wr_value_en  = emu_mode_reg0_reg[MODE_WRITE_VALUE_EN];
   wire comb_en      = emu_mode_reg0_reg[MODE_COMBINED_EN];
   wire step_en      = emu_mode_reg0_reg[MODE_SINGLE_STEP];
   wire br_break_en  = emu_mode_reg0_reg[MODE_BRANCH_BREAK];
   wire int_break_en = emu_mode_reg0_reg[MODE_INTR_BREAK];
   wire lp_break_en  = emu_mode_reg0_reg[MODE_LOOP_BREAK];
   wire tf_break_en  = emu_mode_reg0_reg[MODE_TRACE_FULL];

   // ***************************************************************
   // Program address breakpoints
   // ***************************************************************
   logic [NUM_PROG-1:0] prog_hit;
   logic [NUM_PROG-1:0] prog_fire;
   logic [NUM_PROG-1:0] prog_en;

   // Compare each fetch against the three addresses
   always_comb
   begin
      for (int i = 0; i < NUM_PROG; i++)
      begin
         prog_en[i]   = first_status_reg_reg[ST_PROG_EN_1 + i];
         prog_hit[i]  = fetch_valid & ~handler_active & prog_en[i] & (fetch_addr == prog_cmp_reg[i]);
         // Zero after decrement, or already 0
         prog_fire[i] = prog_hit[i] & (prog_match_counter_reg[i] <= 16'h0001);
      end
   end

   // Comparator and counter registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_PROG; i++)
         begin
            prog_cmp_reg[i]           <= '0;
            prog_match_counter_reg[i] <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < NUM_PROG; i++)
         begin
            if (wr_en && paddr == cmp_ofs(i))
               prog_cmp_reg[i] <= pwdata[ADDR_W-1:0];
            // Counter moves on write or match only
            if (wr_en && paddr == cnt_ofs(i))
               prog_match_counter_reg[i] <= pwdata[15:0];
            // Decrement on match, floor at zero
            else if (prog_hit[i] && prog_match_counter_reg[i] > 16'h0001)
               prog_match_counter_reg[i] <= prog_match_counter_reg[i] - 16'h0001;
            else if (prog_hit[i] && prog_match_counter_reg[i] == 16'h0001)
               prog_match_counter_reg[i] <= 16'h0000;
         end
      end
   end

   // ***************************************************************
   // Data address and value breakpoints
   // ***************************************************************
   // Masked bits are don't-care
   wire addr_eq = ((data_addr ^ data_addr_compare_reg) & ~data_addr_mask_reg) == '0;
   wire addr_hit = data_valid & ~handler_active & addr_eq &
                   (data_write ? wr_addr_en : rd_addr_en);
   // Value match on memory transactions only
   wire value_hit = data_valid & data_mem & ~handler_active & (data_bus == data_value_compare_reg) &
                    (data_write ? wr_value_en : rd_value_en);
   // Combined mode needs both at once
   wire comb_hit   = comb_en & addr_hit & value_hit;
   wire addr_solo  = ~comb_en & addr_hit;
   wire value_solo = ~comb_en & value_hit;

   logic addr_late;
   logic value_late;
   logic comb_late;

   emu_delay_line #(.STAGES(BREAK_DELAY)) addr_delay (
      .pclk       (pclk),
      .presetn    (presetn),
      .instr_done (instr_done),
      .req_in     (addr_solo),
      .req_out    (addr_late)
   );

   emu_delay_line #(.STAGES(BREAK_DELAY)) value_delay (
      .pclk       (pclk),
      .presetn    (presetn),
      .instr_done (instr_done),
      .req_in     (value_solo),
      .req_out    (value_late)
   );

   emu_delay_line #(.STAGES(BREAK_DELAY)) comb_delay (
      .pclk       (pclk),
      .presetn    (presetn),
      .instr_done (instr_done),
      .req_in     (comb_hit),
      .req_out    (comb_late)
   );

   // ***************************************************************
   // Flow events and trace
   // ***************************************************************
   // Branch, non-trap interrupt and loop wrap events
   wire br_fire   = br_break_en & branch_taken & ~handler_active;
   wire int_fire  = int_break_en & intr_start & ~intr_is_trap & ~handler_active;
   wire loop_fire = lp_break_en & loop_wrap & ~handler_active;

   // Only discontinuities outside handler, no traps
   wire trace_push = ~handler_active & (branch_taken | (intr_start & ~intr_is_trap) | loop_wrap);
   wire trace_pop  = rd_en & hit_trc;
   logic [ADDR_W-1:0] trace_head;
   logic              trace_tag;
   logic              trace_full;
   logic              trace_full_d_reg;

   emu_trace_fifo #(.DEPTH(TRACE_DEPTH), .WIDTH(ADDR_W)) trace (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (trace_push),
      .push_addr (flow_addr),
      .push_tag  (~flow_two_word),
      .pop       (trace_pop),
      .head_addr (trace_head),
      .head_tag  (trace_tag),
      .full      (trace_full)
   );

   // Break on the cycle the buffer becomes full
   wire tf_fire = tf_break_en & trace_full & ~trace_full_d_reg;

   // Arm on handler return, fire after one instruction
   wire step_fire = step_armed_reg & instr_done;

   wire any_fire = (|prog_fire) | addr_late | value_late | comb_late |
                   br_fire | int_fire | loop_fire | tf_fire | step_fire;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         step_armed_reg   <= 1'b0;
         bi_reg           <= 1'b0;
         trace_full_d_reg <= 1'b0;
      end
      else
      begin
         trace_full_d_reg <= trace_full;
         bi_reg           <= any_fire;
         if (handler_return && step_en)
            step_armed_reg <= 1'b1;
         else if (instr_done)
            step_armed_reg <= 1'b0;
      end
   end

   assign breakpoint_interrupt = bi_reg;

   // ***************************************************************
   // Status, mode and data compare registers
   // ***************************************************************
   // Cause bits: hardware set wins over software clear
   wire [15:0] cause_set = {loop_fire, step_fire, tf_fire, int_fire, br_fire, 3'b000,
                            prog_fire, 2'b00, comb_late, addr_late, value_late};
   // Enables stay software-only; only cause bits are hardware-set
   wire [15:0] en_mask   = 16'h0700;
   wire [15:0] status_next = (wr_en && hit_stat)
                             ? ((pwdata[15:0] | cause_set) & ~16'h00E0) | (pwdata[15:0] & 16'h00E0) | cause_set
                             : first_status_reg_reg | (cause_set & ~en_mask);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         emu_mode_reg0_reg      <= MODE_RESET;
         first_status_reg_reg   <= STATUS_RESET;
         data_addr_compare_reg  <= '0;
         data_addr_mask_reg     <= '0;
         data_value_compare_reg <= '0;
      end
      else
      begin
         // Enables written, flags set by match
         first_status_reg_reg <= status_next;
         if (wr_en && hit_mode)
            emu_mode_reg0_reg <= pwdata[15:0];
         if (wr_en && hit_dadr)
            data_addr_compare_reg <= pwdata[ADDR_W-1:0];
         if (wr_en && hit_dmsk)
            data_addr_mask_reg <= pwdata[ADDR_W-1:0];
         if (wr_en && hit_dval)
            data_value_compare_reg <= pwdata[DATA_W-1:0];
      end
   end

   // ***************************************************************
   // APB read mux
   // ***************************************************************
   logic [15:0] rd_word;
   logic        rd_known;

   always_comb
   begin
      rd_word  = 16'h0000;
      rd_known = 1'b1;
      case (paddr)
         OFS_PROG_CMP_1: rd_word = prog_cmp_reg[0];
         OFS_PROG_CMP_2: rd_word = prog_cmp_reg[1];
         OFS_PROG_CMP_3: rd_word = prog_cmp_reg[2];
         OFS_PROG_CNT_1: rd_word = prog_match_counter_reg[0];
         OFS_PROG_CNT_2: rd_word = prog_match_counter_reg[1];
         OFS_PROG_CNT_3: rd_word = prog_match_counter_reg[2];
         OFS_DATA_ADDR:  rd_word = data_addr_compare_reg;
         OFS_DATA_MASK:  rd_word = data_addr_mask_reg;
         OFS_DATA_VALUE: rd_word = data_value_compare_reg;
         OFS_EMU_MODE_REG0:      rd_word = emu_mode_reg0_reg;
         OFS_FIRST_STATUS_REG:    rd_word = first_status_reg_reg;
         OFS_STATUS1:    rd_word = {15'h0000, trace_tag};
         OFS_TRACE_READ: rd_word = trace_head;
         default:        rd_known = 1'b0;
      endcase
   end

   // Zero-wait slave; unmapped addresses error
   assign pready  = 1'b1;
   assign pslverr = access & ~rd_known;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {16'h0000, rd_word};
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   prog_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (prog_hit[1] && !(wr_en && paddr == cnt_ofs(1)) && prog_match_counter_reg[1] > 16'h0001)
      |=> prog_match_counter_reg[1] == $past(prog_match_counter_reg[1]) - 16'h0001)
      else $error("counter did not decrement");

   prog_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!prog_hit[1] && !(wr_en && paddr == cnt_ofs(1))) |=> $stable(prog_match_counter_reg[1]))
      else $error("counter moved without cause");

   prog_break_a: assert property (@(posedge pclk) disable iff (!presetn)
      prog_fire[1] |=> breakpoint_interrupt && first_status_reg_reg[ST_PROG_FLAG_1 + 1])
      else $error("program match did not break");

   prog_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !first_status_reg_reg[ST_PROG_EN_1 + 1] |-> !prog_hit[1])
      else $error("disabled comparator matched");

   value_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
      value_late |=> breakpoint_interrupt && first_status_reg_reg[ST_DATA_VALUE])
      else $error("value break not raised");

   nonmem_value_a: assert property (@(posedge pclk) disable iff (!presetn)
      (data_valid && !data_mem) |-> !value_hit)
      else $error("value match outside memory access");

   comb_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      comb_late |=> first_status_reg_reg[ST_COMBINED] && breakpoint_interrupt)
      else $error("combined break not flagged");

   step_break_a: assert property (@(posedge pclk) disable iff (!presetn)
      (step_armed_reg && instr_done && !handler_return) |=> breakpoint_interrupt && !step_armed_reg)
      else $error("single step missed");

   any_break_a: assert property (@(posedge pclk) disable iff (!presetn)
      (br_fire || loop_fire || int_fire) |=> breakpoint_interrupt)
      else $error("flow event did not break");

endmodule
`default_nettype wire

// ### testbench/core_model.sv
// Core stand-in: fetch, data and flow strobes toward the emulation unit.
// Assumes the bench calls strobe; every strobe lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module core_model
   import emu_pkg::*;
(
   // Clock
   input  wire logic              pclk,
   // Strobes and buses
   output logic                   fv,
   output logic                   dv,
   output logic                   done,
   output logic      [1:0]        dctl,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] dbus,
   output logic      [6:0]        ev
);
   // Idle buses show the inverse, so a held copy never matches by luck
   task automatic strobe(input logic [2:0] s, input logic [1:0] c, input logic [15:0] a, d, input logic [6:0] e);
      @(posedge pclk);
      {fv, dv, done} <= s;
      dctl <= c;
      addr <= a;
      dbus <= d;
      ev <= e;
      @(posedge pclk);
      {fv, dv, done} <= 3'b000;
      addr <= ~a;
      dbus <= ~d;
      ev <= 7'h00;
   endtask
   initial
   begin
      {fv, dv, done} = 3'b000;
      dctl = 2'b00;
      addr = 16'h0000;
      dbus = 16'h0000;
      ev = 7'h00;
   end
endmodule
`default_nettype wire

// ### testbench/dsp_emulation_breakpoint_trace_bench.sv
// Bench: APB register tasks plus core strobes, counting break pulses.
// Assumes core_model on the core side; assertions sit in the design.
`timescale 1ns/1ps
`default_nettype none
module dsp_emulation_breakpoint_trace_bench;
   import emu_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bi, perr;
   logic        fv, dv, done;
   logic [1:0]  dctl;
   logic [6:0]  ev;
   logic [7:0]  paddr;
   logic [15:0] addr, dbus;
   logic [31:0] pwdata, prdata, q;
   int          err_total = 0, check_count = 0, irq_n = 0, n;
   int          mb [4] = '{6, 7, 7, 8};
   logic [6:0]  evs [4] = '{7'h01, 7'h06, 7'h02, 7'h08};
   int          inc [4] = '{1, 0, 1, 1};
   emu_breakpoint dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .fetch_valid(fv), .fetch_addr(addr), .instr_done(done), .data_valid(dv), .data_write(dctl[1]),
      .data_mem(dctl[0]), .data_addr(addr), .data_bus(dbus), .branch_taken(ev[0]), .intr_start(ev[1]),
      .intr_is_trap(ev[2]), .loop_wrap(ev[3]), .flow_addr(addr), .flow_two_word(ev[4]),
      .handler_active(ev[5]), .handler_return(ev[6]), .breakpoint_interrupt(bi));
   core_model core (.pclk, .fv, .dv, .done, .dctl, .addr, .dbus, .ev);
   // Clock and break pulse counter
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) if (bi === 1'b1) irq_n <= irq_n + 1;
   // One APB transfer; read data left in q
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, seen);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Room for the one-cycle break pulse to land
   task automatic settle;
      repeat (3) @(posedge pclk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      close_out;
   end
   initial
   begin
      {psel, penable, pwrite, presetn} = 4'b0000;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_EMU_MODE_REG0, 0);
      chk("mode reset", MODE_RESET, q);
      apb(0, 8'h40, 0);
      chk("unmapped read", 0, q);
      chk("unmapped error", 1, perr);
      $display("test reset done");
      apb(1, OFS_PROG_CMP_2, 32'h0100);
      apb(1, OFS_PROG_CNT_2, 32'h2);
      apb(1, OFS_FIRST_STATUS_REG, 32'h1 << (ST_PROG_EN_1 + 1));
      core.strobe(3'b100, 0, 16'h0100, 0, 0);
      core.strobe(3'b100, 0, 16'h0104, 0, 0);
      settle;
      chk("first hit", 0, irq_n);
      core.strobe(3'b100, 0, 16'h0100, 0, 0);
      settle;
      chk("second hit", 1, irq_n);
      apb(0, OFS_FIRST_STATUS_REG, 0);
      chk("match flag", 1, q[ST_PROG_FLAG_1 + 1]);
      core.strobe(3'b100, 0, 16'h0100, 0, 0);
      settle;
      chk("count floor", 2, irq_n);
      apb(1, OFS_FIRST_STATUS_REG, 0);
      core.strobe(3'b100, 0, 16'h0100, 0, 0);
      settle;
      chk("disabled", 2, irq_n);
      $display("test program break done");
      apb(1, OFS_DATA_ADDR, 32'h2000);
      apb(1, OFS_DATA_MASK, 32'h000F);
      apb(1, OFS_DATA_VALUE, 32'h55AA);
      apb(1, OFS_EMU_MODE_REG0, 32'h1 << MODE_READ_ADDR_EN);
      core.strobe(3'b010, 2'b01, 16'h2005, 16'h1234, 0);
      core.strobe(3'b001, 0, 0, 0, 0);
      settle;
      chk("one retired", 2, irq_n);
      core.strobe(3'b001, 0, 0, 0, 0);
      settle;
      chk("masked addr", 3, irq_n);
      apb(1, OFS_EMU_MODE_REG0, 32'h1 << MODE_READ_VALUE_EN);
      for (int m = 0; m < 2; m++)
      begin
         core.strobe(3'b010, m[1:0], 16'h0700, 16'h55AA, 0);
         repeat (2) core.strobe(3'b001, 0, 0, 0, 0);
         settle;
         chk("value break", 3 + m, irq_n);
      end
      apb(1, OFS_FIRST_STATUS_REG, 0);
      apb(1, OFS_EMU_MODE_REG0, 32'h15);
      for (int m = 0; m < 2; m++)
      begin
         core.strobe(3'b010, 2'b01, 16'h2003, m ? 16'h55AA : 16'h1111, 0);
         repeat (2) core.strobe(3'b001, 0, 0, 0, 0);
         settle;
         chk("combined", 4 + m, irq_n);
      end
      apb(0, OFS_FIRST_STATUS_REG, 0);
      chk("combined flag", 1, q[ST_COMBINED]);
      $display("test data break done");
      for (int i = 0; i < 4; i++)
      begin
         n = irq_n;
         apb(1, OFS_EMU_MODE_REG0, 32'h1 << mb[i]);
         core.strobe(0, 0, 16'h0340 + i, 0, evs[i]);
         settle;
         chk("flow break", n + inc[i], irq_n);
         if (i == 0)
         begin
            apb(0, OFS_TRACE_READ, 0);
            chk("trace head", 32'h0340, q);
         end
      end
      apb(1, OFS_EMU_MODE_REG0, 32'h1 << MODE_SINGLE_STEP);
      core.strobe(0, 0, 0, 0, 7'h40);
      core.strobe(3'b001, 0, 0, 0, 0);
      settle;
      chk("single step", n + 2, irq_n);
      apb(0, OFS_STATUS1, 0);
      chk("trace tag", 1, q[0]);
      apb(0, OFS_TRACE_READ, 0);
      chk("trace newest", 32'h0343, q);
      apb(0, OFS_TRACE_READ, 0);
      chk("trace next", 32'h0342, q);
      apb(0, OFS_TRACE_READ, 0);
      chk("trace drained", 32'hFFFF, q);
      apb(1, OFS_EMU_MODE_REG0, 32'h1 << MODE_TRACE_FULL);
      n = irq_n;
      repeat (TRACE_DEPTH) core.strobe(0, 0, 16'h0500, 0, 7'h01);
      settle;
      chk("trace full", n + 1, irq_n);
      $display("test flow break done");
      close_out;
   end
endmodule
`default_nettype wire
